// File: design/eight_bit_sync_serial_port.sv
// Eight-bit synchronous serial port with APB registers and shift clock generation.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

// Summary of operation
// - Start with internal clock clears counter, begins.
// - Start with external clock clears counter, waits.
// - Eighth rising edge sets flag, clears start.
// - Writing start zero aborts transfer, stops shifting.
// - Flag clears on zero write, one ignored.
// - Interrupt line high when flag and enable.
// - Flag set on completion regardless of enable.
// - Start cleared at completion cycle: no flag.
// - Enabling with flag set raises interrupt immediately.
// - Order bit: zero LSB first, one MSB first.
// - Order applied at data access, not stored.
// - Select: 2, 8, 32 cycles or external.
// - Internal clock with output enable drives pin.
// - External selection takes shift clock from pin.
// - Data output enable drives shift output pin.
// - Shift out and in simultaneously per clock.
// - Data register sends written byte, holds received.
// - No data writes during transfer; reads meaningless.
// - Request six, level bits 5:4, vector FFE6.
// - Counter counts shifts, stops idle, clears restart.
// - Output changes falling edge, input samples rising.
module eight_bit_sync_serial_port (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sckIn,
  input  wire logic                      siIn,
  input  wire sync_serial_pkg::gp_port_t gpPort,
  output sync_serial_pkg::pin_out_t      pinOut,
  output logic                           serialIrqLine,
  output logic      [1:0]                irqLevel
);

  logic       xferDoneFlag;
  logic       doneIrqEnable;
  logic       clkOutEnable;
  logic       doutEnable;
  logic [1:0] clkSel;
  logic       bitOrderSel;
  logic       xferGo;
  logic [7:0] shiftReg;
  logic [2:0] shiftCount;
  logic [4:0] divCount;
  logic       sckInt;
  logic       soBit;
  logic       sckMeta;
  logic       sckSync;
  logic       sckLast;
  logic       siMeta;
  logic       siSync;
  logic       access;
  logic       modeWr;
  logic       dataWr;
  logic       levelWr;
  logic       internalClk;
  logic [4:0] halfDiv;
  logic       intToggle;
  logic       shiftRise;
  logic       shiftFall;
  logic       lastShift;
  logic       doneSet;
  logic [7:0] modeRead;
  logic [7:0] dataRead;
  logic [7:0] next_shiftWrite;
  logic [2:0] riseDelay;
  logic [2:0] lastDelay;
  logic       rxStrobe;
  logic       rxDone;
  logic [7:0] rxShift;

  // The bus answers one cycle into the access phase; writes land on the edge that sees pready.
  assign access  = psel && penable && pready;
  assign modeWr  = access && pwrite && (paddr == sync_serial_pkg::MODE_ADDR);
  assign dataWr  = access && pwrite && (paddr == sync_serial_pkg::DATA_ADDR);
  assign levelWr = access && pwrite && (paddr == sync_serial_pkg::LEVEL_ADDR);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        if (paddr == sync_serial_pkg::MODE_ADDR) begin
          prdata <= {24'h00_0000, modeRead};
        end else if (paddr == sync_serial_pkg::DATA_ADDR) begin
          prdata <= {24'h00_0000, dataRead};
        end else if (paddr == sync_serial_pkg::LEVEL_ADDR) begin
          prdata <= {26'h000_0000, irqLevel, 4'h0};
        end else begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  assign modeRead = {xferDoneFlag, doneIrqEnable, clkOutEnable, doutEnable,
                     clkSel, bitOrderSel, xferGo};

  // Bytes are kept in shift order, so reordering happens only at the bus.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dataRead[i]        = bitOrderSel ? shiftReg[7 - i] : shiftReg[i];
      next_shiftWrite[i] = bitOrderSel ? pwdata[7 - i]   : pwdata[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneIrqEnable <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::IRQ_EN_BIT];
      clkOutEnable  <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::CLK_OE_BIT];
      doutEnable    <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::DOUT_EN_BIT];
      clkSel        <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::CLK_SEL_HI_BIT:
                                                   sync_serial_pkg::CLK_SEL_LO_BIT];
      bitOrderSel   <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::ORDER_BIT];
    end else if (modeWr) begin
      doneIrqEnable <= pwdata[sync_serial_pkg::IRQ_EN_BIT];
      clkOutEnable  <= pwdata[sync_serial_pkg::CLK_OE_BIT];
      doutEnable    <= pwdata[sync_serial_pkg::DOUT_EN_BIT];
      clkSel        <= pwdata[sync_serial_pkg::CLK_SEL_HI_BIT:sync_serial_pkg::CLK_SEL_LO_BIT];
      bitOrderSel   <= pwdata[sync_serial_pkg::ORDER_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqLevel <= sync_serial_pkg::LEVEL_RESET;
    end else if (levelWr) begin
      irqLevel <= pwdata[sync_serial_pkg::LEVEL_HI_BIT:sync_serial_pkg::LEVEL_LO_BIT];
    end
  end

  // Two-stage synchronisers; the pin's shift clock is treated as plain data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckMeta <= 1'b1;
      sckSync <= 1'b1;
      sckLast <= 1'b1;
      siMeta  <= 1'b1;
      siSync  <= 1'b1;
    end else begin
      sckMeta <= sckIn;
      sckSync <= sckMeta;
      sckLast <= sckSync;
      siMeta  <= siIn;
      siSync  <= siMeta;
    end
  end

  assign internalClk = (clkSel != sync_serial_pkg::CLK_EXT);

  always_comb begin
    case (clkSel)
      sync_serial_pkg::CLK_DIV2:  halfDiv = sync_serial_pkg::HALF_DIV2;
      sync_serial_pkg::CLK_DIV8:  halfDiv = sync_serial_pkg::HALF_DIV8;
      default:                    halfDiv = sync_serial_pkg::HALF_DIV32;
    endcase
  end

  // The internal shift clock idles high and restarts its phase on every start write.
  assign intToggle = xferGo && internalClk && (divCount == halfDiv - 5'h01);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCount <= 5'h00;
      sckInt   <= 1'b1;
    end else if (!xferGo || modeWr) begin
      divCount <= 5'h00;
      sckInt   <= 1'b1;
    end else if (intToggle) begin
      divCount <= 5'h00;
      sckInt   <= !sckInt;
    end else begin
      divCount <= divCount + 5'h01;
    end
  end

  // Only external edges while external is selected reach the shifter.
  assign shiftRise = xferGo && (internalClk ? (intToggle && !sckInt) : (sckSync && !sckLast));
  assign shiftFall = xferGo && (internalClk ? (intToggle && sckInt) : (!sckSync && sckLast));
  assign lastShift = shiftRise && (shiftCount == sync_serial_pkg::LAST_BIT);
  // A start bit cleared in the completing cycle suppresses the flag.
  assign doneSet   = lastShift && !(modeWr && !pwdata[sync_serial_pkg::GO_BIT]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xferGo <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::GO_BIT];
    end else if (modeWr) begin
      xferGo <= pwdata[sync_serial_pkg::GO_BIT];
    end else if (lastShift) begin
      xferGo <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftCount <= 3'h0;
    end else if (modeWr && pwdata[sync_serial_pkg::GO_BIT]) begin
      shiftCount <= 3'h0;
    end else if (shiftRise) begin
      shiftCount <= shiftCount + 3'h1;
    end
  end

  // A completion in the same cycle as a clearing write wins over the clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xferDoneFlag <= sync_serial_pkg::MODE_RESET[sync_serial_pkg::FLAG_BIT];
    end else if (doneSet) begin
      xferDoneFlag <= 1'b1;
    end else if (modeWr && !pwdata[sync_serial_pkg::FLAG_BIT]) begin
      xferDoneFlag <= 1'b0;
    end
  end

  // The pin clock lags the internal one by a clk and the answer needs two more to pass the
  // synchroniser, so internal bits are taken three clks after each rise. Without this the
  // fastest clock would read the previous bit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      riseDelay <= 3'h0;
      lastDelay <= 3'h0;
    end else begin
      riseDelay <= {riseDelay[1:0], shiftRise && internalClk};
      lastDelay <= {lastDelay[1:0], lastShift && internalClk};
    end
  end

  assign rxStrobe = riseDelay[2];
  assign rxDone   = lastDelay[2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxShift <= sync_serial_pkg::DATA_RESET;
    end else if (rxStrobe) begin
      rxShift <= {siSync, rxShift[7:1]};
    end
  end

  // Data writes during a transfer are the user's hazard; they simply overwrite the shifter.
  // With an internal clock the received byte lands three clks after the flag is set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shiftReg <= sync_serial_pkg::DATA_RESET;
    end else if (dataWr) begin
      shiftReg <= next_shiftWrite;
    end else if (rxDone) begin
      shiftReg <= {siSync, rxShift[7:1]};
    end else if (shiftRise) begin
      shiftReg <= {siSync, shiftReg[7:1]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soBit <= 1'b1;
    end else if (shiftFall) begin
      soBit <= shiftReg[0];
    end
  end

  // The irq line lags the flag by one clock because every output is registered.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialIrqLine <= 1'b0;
      pinOut        <= '{sckOut: 1'b1, sckOeN: 1'b1, soOut: 1'b1, soOeN: 1'b1};
    end else begin
      serialIrqLine <= xferDoneFlag && doneIrqEnable;
      pinOut.sckOut <= clkOutEnable ? sckInt : gpPort.clkData;
      pinOut.sckOeN <= !(clkOutEnable || gpPort.clkDir);
      pinOut.soOut  <= doutEnable ? soBit : gpPort.doutData;
      pinOut.soOeN  <= !(doutEnable || gpPort.doutDir);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence startWrite;
    modeWr && pwdata[sync_serial_pkg::GO_BIT];
  endsequence

  sequence finalEdge;
    shiftRise && (shiftCount == sync_serial_pkg::LAST_BIT);
  endsequence

  a_start_clears_count: assert property (startWrite |=> shiftCount == 3'h0 && xferGo)
    else $error("start write did not clear the shift counter");

  a_ext_waits_edge: assert property (
      xferGo && !internalClk && !(sckSync && !sckLast) && !modeWr |=> $stable(shiftCount))
    else $error("external transfer shifted without a clock edge");

  a_done_sets_flag: assert property (finalEdge ##0 !modeWr |=> xferDoneFlag && !xferGo)
    else $error("completion did not set flag and clear start");

  a_abort_stops: assert property (
      modeWr && !pwdata[sync_serial_pkg::GO_BIT] |=> !xferGo ##1 $stable(shiftCount))
    else $error("abort did not stop the transfer");

  a_flag_clear: assert property (
      modeWr && !pwdata[sync_serial_pkg::FLAG_BIT] && !doneSet |=> !xferDoneFlag)
    else $error("zero write did not clear the flag");

  a_flag_keep: assert property (
      modeWr && pwdata[sync_serial_pkg::FLAG_BIT]
      |=> xferDoneFlag == ($past(xferDoneFlag) || $past(doneSet)))
    else $error("one write changed the flag");

  a_irq_follows: assert property (xferDoneFlag && doneIrqEnable |=> serialIrqLine)
    else $error("interrupt line missing with flag and enable set");

  a_irq_enable_rise: assert property (
      xferDoneFlag && $rose(doneIrqEnable) |-> ##1 serialIrqLine)
    else $error("enabling with flag set did not raise interrupt");

  a_race_no_flag: assert property (
      finalEdge ##0 (modeWr && !pwdata[sync_serial_pkg::GO_BIT])
      |=> xferDoneFlag == ($past(xferDoneFlag) && $past(pwdata[sync_serial_pkg::FLAG_BIT])))
    else $error("flag set although start was cleared at completion");

  a_order_write: assert property (
      dataWr && pwdata[sync_serial_pkg::ORDER_BIT - 1] == 1'b0 && bitOrderSel
      |=> shiftReg[0] == $past(pwdata[7]))
    else $error("msb first write not placed first in shift order");

  a_div2_period: assert property (
      xferGo && internalClk && clkSel == sync_serial_pkg::CLK_DIV2 && shiftRise && !modeWr
      && shiftCount != sync_serial_pkg::LAST_BIT |-> ##1 shiftFall)
    else $error("two-cycle shift clock did not fall one cycle after rise");

  a_sck_drive: assert property (clkOutEnable |=> !pinOut.sckOeN)
    else $error("clock pin not driven with clock output enabled");

  a_dout_drive: assert property (
      doutEnable |=> !pinOut.soOeN && pinOut.soOut == $past(soBit))
    else $error("data pin not driven from shift output");

  a_idle_count: assert property (!xferGo && !modeWr |=> $stable(shiftCount))
    else $error("shift counter moved while idle");

endmodule : eight_bit_sync_serial_port

// File: design/sync_serial_pkg.sv
// Package with register map, field positions, timing constants and pin types of the serial port.
package sync_serial_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [9:0]  MODE_IDX       = 10'h01c;
  localparam logic [9:0]  DATA_IDX       = 10'h01d;
  localparam logic [9:0]  LEVEL_IDX      = 10'h07d;
  localparam logic [11:0] MODE_ADDR      = {MODE_IDX, 2'b00};
  localparam logic [11:0] DATA_ADDR      = {DATA_IDX, 2'b00};
  localparam logic [11:0] LEVEL_ADDR     = {LEVEL_IDX, 2'b00};

  // Mode register field positions.
  localparam int          FLAG_BIT       = 7;
  localparam int          IRQ_EN_BIT     = 6;
  localparam int          CLK_OE_BIT     = 5;
  localparam int          DOUT_EN_BIT    = 4;
  localparam int          CLK_SEL_HI_BIT = 3;
  localparam int          CLK_SEL_LO_BIT = 2;
  localparam int          ORDER_BIT      = 1;
  localparam int          GO_BIT         = 0;
  localparam logic [7:0]  MODE_RESET     = 8'h00;

  // Interrupt routing of this port: request number, level field and vector.
  localparam int          IRQ_NUMBER     = 6;
  localparam int          LEVEL_HI_BIT   = 5;
  localparam int          LEVEL_LO_BIT   = 4;
  localparam logic [15:0] IRQ_VECTOR     = 16'hffe6;
  localparam logic [1:0]  LEVEL_RESET    = 2'h3;

  // Shift clock periods are given in instruction cycles; one instruction cycle is one clk.
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          TINST_NS       = 25;
  localparam int          TINST_CYC      = TINST_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  HALF_DIV2      = 5'((2 * TINST_CYC) / 2);
  localparam logic [4:0]  HALF_DIV8      = 5'((8 * TINST_CYC) / 2);
  localparam logic [4:0]  HALF_DIV32     = 5'((32 * TINST_CYC) / 2);
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [7:0]  DATA_RESET     = 8'h00;

  typedef enum logic [1:0] {
    CLK_DIV2  = 2'h0,
    CLK_DIV8  = 2'h1,
    CLK_DIV32 = 2'h2,
    CLK_EXT   = 2'h3
  } clk_sel_t;

  // Levels seen by the pads; an enable low means the port drives the pin.
  typedef struct packed {
    logic sckOut;
    logic sckOeN;
    logic soOut;
    logic soOeN;
  } pin_out_t;

  // General-purpose port settings that the serial port overrides.
  typedef struct packed {
    logic clkDir;
    logic clkData;
    logic doutDir;
    logic doutData;
  } gp_port_t;

endpackage : sync_serial_pkg

// File: sim/eight_bit_sync_serial_port_test.sv
// Self-checking bench for the serial port: registers, every shift clock and abort.
`timescale 1ns/1ps
module eight_bit_sync_serial_port_test;
  localparam logic [11:0]    MODE_A = sync_serial_pkg::MODE_ADDR;
  localparam logic [11:0]    DATA_A = sync_serial_pkg::DATA_ADDR;
  localparam logic [11:0]    LVL_A  = sync_serial_pkg::LEVEL_ADDR;
  logic                      clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                      sckIn, siIn, msbFirst, sckExt, serialIrqLine, perr;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata;
  logic [1:0]                irqLevel;
  logic [7:0]                peerTx, devTx, rdv;
  logic [3:0]                nSeen, portExp;
  sync_serial_pkg::gp_port_t gpPort;
  sync_serial_pkg::pin_out_t pinOut;
  int                        n_errors, checks_done;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  assign sckIn = pinOut.sckOeN ? sckExt : pinOut.sckOut;

  eight_bit_sync_serial_port DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sckIn(sckIn), .siIn(siIn), .gpPort(gpPort), .pinOut(pinOut),
    .serialIrqLine(serialIrqLine), .irqLevel(irqLevel));

  serial_peer peer (.sck(sckIn), .so(pinOut.soOeN ? 1'b1 : pinOut.soOut),
    .msbFirst(msbFirst), .txByte(peerTx), .si(siIn), .sckExt(sckExt));

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      complete_run();
    end
    rdv = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Sets up and starts one byte; with full set it also waits for the end and checks both bytes.
  task automatic xfer(input logic [1:0] sel, input logic ie, input logic full);
    logic       ord;
    logic [7:0] m;
    int         k;
    ord = 1'($urandom);
    m = {1'b0, ie, sel != 2'h3, 1'b1, sel, ord, 1'b0};
    devTx = 8'($urandom);
    peerTx = 8'($urandom);
    msbFirst = ord;
    gpPort <= 4'($urandom) & ((sel == 2'h3) ? 4'h7 : 4'hf);
    apb(1'b1, MODE_A, m);
    apb(1'b1, DATA_A, devTx);
    peer.arm();
    apb(1'b1, MODE_A, m | 8'h01);
    @(negedge clk);
    if (sel != 2'h3)
      chk("clock pin drive", 8'h00, {7'h0, pinOut.sckOeN});
    chk("data pin drive", 8'h00, {7'h0, pinOut.soOeN});
    @(posedge clk);
    if (!full)
      return;
    // The peer's clock edges fall between bench edges so none races the sampling flops.
    if (sel == 2'h3) begin
      @(negedge clk);
      peer.genByte();
    end
    k = 0;
    do begin
      apb(1'b0, MODE_A, 8'h00);
      k++;
    end while (rdv[0] !== 1'b0 && k < 300);
    if (rdv[0] !== 1'b0) begin
      n_errors++;
      complete_run();
    end
    chk("mode at end", m | 8'h80, rdv);
    chk("irq at end", {7'h0, ie}, {7'h0, serialIrqLine});
    apb(1'b0, DATA_A, 8'h00);
    chk("received byte", peerTx, rdv);
    chk("sent byte", devTx, peer.rxByte);
  endtask : xfer

  initial begin
    void'($urandom(10395));
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    msbFirst = 1'b0;
    peerTx = 8'h00;
    gpPort = 4'($urandom);
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("level pins", 8'h03, {6'h00, irqLevel});
    apb(1'b0, MODE_A, 8'h00);
    chk("mode reset", sync_serial_pkg::MODE_RESET, rdv);
    apb(1'b0, LVL_A, 8'h00);
    chk("level reset", 8'h30, rdv);
    apb(1'b1, LVL_A, 8'h10);
    chk("level set", 8'h01, {6'h00, irqLevel});
    apb(1'b0, 12'h000, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, perr});
    for (int s = 0; s < 4; s++) begin
      xfer(2'(s), 1'b1, 1'b1);
      apb(1'b1, MODE_A, 8'h40);
      apb(1'b0, MODE_A, 8'h00);
      chk("flag cleared", 8'h40, rdv);
      chk("irq cleared", 8'h00, {7'h0, serialIrqLine});
      portExp = {gpPort.clkData, !gpPort.clkDir, gpPort.doutData, !gpPort.doutDir};
      chk("port passthrough", {4'h0, portExp}, {4'h0, pinOut});
    end
    xfer(2'h0, 1'b0, 1'b1);
    apb(1'b1, MODE_A, 8'hc0);
    apb(1'b0, MODE_A, 8'h00);
    chk("flag kept", 8'hc0, rdv);
    chk("irq on enable", 8'h01, {7'h0, serialIrqLine});
    apb(1'b1, MODE_A, 8'h00);
    // A stop written with the flag bit high lands on the eighth rise of a fast byte.
    xfer(2'h0, 1'b0, 1'b0);
    repeat (11) @(posedge clk);
    apb(1'b1, MODE_A, 8'hb0);
    apb(1'b0, MODE_A, 8'h00);
    chk("no flag on stop at end", 8'h30, rdv);
    // Abort a slow byte part way, then check that a restart runs a whole byte again.
    xfer(2'h2, 1'b0, 1'b0);
    repeat (60) @(posedge clk);
    apb(1'b1, MODE_A, 8'h38);
    nSeen = peer.nBits;
    repeat (100) @(posedge clk);
    chk("edges after abort", {4'h0, nSeen}, {4'h0, peer.nBits});
    apb(1'b0, MODE_A, 8'h00);
    chk("mode after abort", 8'h38, rdv);
    xfer(2'h2, 1'b1, 1'b1);
    complete_run();
  end
endmodule : eight_bit_sync_serial_port_test

// File: sim/serial_peer.sv
// Behavioural model of the external serial peer that swaps one byte per frame.
`timescale 1ns/1ps
module serial_peer (
  input  wire logic       sck,
  input  wire logic       so,
  input  wire logic       msbFirst,
  input  wire logic [7:0] txByte,
  output logic            si,
  output logic            sckExt
);
  logic [7:0] rxByte;
  logic [3:0] nBits;

  initial begin
    si = 1'b1;
    sckExt = 1'b1;
    rxByte = 8'h00;
    nBits = 4'h0;
  end

  always @(negedge sck) begin
    if (nBits < 4'h8)
      si = msbFirst ? txByte[3'h7 - nBits[2:0]] : txByte[nBits[2:0]];
  end

  // After the last bit the line stops holding its value once the hold time is over.
  always @(posedge sck) begin
    rxByte = msbFirst ? {rxByte[6:0], so} : {so, rxByte[7:1]};
    nBits = nBits + 4'h1;
    if (nBits == 4'h8)
      si <= #150 ~si;
  end

  task automatic arm();
    nBits = 4'h0;
  endtask : arm

  // The clock idles high and runs only while a byte is being clocked.
  task automatic genByte();
    repeat (8) begin
      #100 sckExt = 1'b0;
      #100 sckExt = 1'b1;
    end
  endtask : genByte
endmodule : serial_peer
